// file: hdl/link_mode_consts.svh
// constants for the link mode configuration and resolution block
`ifndef LINK_MODE_CONSTS_SVH
`define LINK_MODE_CONSTS_SVH
`define CTRL_BIT_SPEED_LSB 13
`define CTRL_BIT_AUTONEG_ENABLE_STRAP 12
`define CTRL_BIT_RESTART 9
`define CTRL_BIT_DUPLEX 8
`define CTRL_BIT_SPEED_MSB 6
`define MS_BIT_MANUAL 12
`define MS_BIT_MASTER 11
`define GSTAT_BIT_MS_FAULT 15
`define CTRL_RST_VAL 16'h0000
`define MS_RST_VAL 16'h0000
`define SPD_10 2'h0
`define SPD_100 2'h1
`define SPD_1000 2'h2
`define SPD_RSVD 2'h3
`define FLP_GAP_US 16
`define CLK_MHZ 10
`define FLP_GAP_CYC ((`FLP_GAP_US * `CLK_MHZ) > 0 ? (`FLP_GAP_US * `CLK_MHZ) : 1)
`define FLP_BURST_PULSES 8'h21
`endif

// file: hdl/link_mode_pkg.sv
// types for link mode configuration and resolution
package link_mode_pkg;
    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_FORCED = 5'h02,
        ST_NEGOTIATE = 5'h04,
        ST_LINKED = 5'h08,
        ST_FAULT = 5'h10
    } an_state_t;

    // ability vector: [5]=1000fd [4]=1000hd [3]=100fd [2]=100hd [1]=10fd [0]=10hd
    typedef logic [5:0] ability_t;
endpackage : link_mode_pkg

// file: hdl/mode_sel_if.sv
// burst request and advertised ability word handed from the resolver to the flp pulse sender
`timescale 1ns/1ns
interface mode_sel_if;
    logic burst_req;
    logic burst_busy;
    logic [5:0] adv_word;
    modport ctrl (output burst_req, output adv_word, input burst_busy);
    modport gen (input burst_req, input adv_word, output burst_busy);
endinterface : mode_sel_if

// file: hdl/flp_burst_gen.sv
// fast link pulse burst sender carrying the advertised abilities
`timescale 1ns/1ns
`include "link_mode_consts.svh"
module flp_burst_gen (
    input wire logic ref_clk_i, // system clock
    input wire logic rst_i, // sync reset, high
    mode_sel_if.gen ms, // burst request and ability word
    output logic flp_pulse_o // one clock pulse per link pulse
);
    typedef struct packed {
        logic busy;
        logic [7:0] pulse_cnt;
        logic [15:0] gap_cnt;
        logic [5:0] word;
        logic pulse;
    } gen_state_t;

    gen_state_t s_r;
    gen_state_t s_nxt;

    always_comb begin
        s_nxt = s_r;
        s_nxt.pulse = 1'b0;
        if (!s_r.busy) begin
            if (ms.burst_req) begin
                s_nxt.busy = 1'b1;
                s_nxt.word = ms.adv_word;
                s_nxt.pulse_cnt = 8'h00;
                s_nxt.gap_cnt = 16'h0000;
            end
        end else if (s_r.gap_cnt == 16'((`FLP_GAP_CYC) - 1)) begin
            s_nxt.gap_cnt = 16'h0000;
            // even slots are clocks, odd slots carry ability bits (low bits only)
            if (!s_r.pulse_cnt[0] || (s_r.pulse_cnt[3:1] < 3'h6 && s_r.word[s_r.pulse_cnt[3:1]]))
                s_nxt.pulse = 1'b1;
            s_nxt.pulse_cnt = s_r.pulse_cnt + 8'h01;
            if (s_r.pulse_cnt == `FLP_BURST_PULSES - 8'h01)
                s_nxt.busy = 1'b0;
        end else begin
            s_nxt.gap_cnt = s_r.gap_cnt + 16'h0001;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign ms.burst_busy = s_r.busy;
    assign flp_pulse_o = s_r.pulse;
endmodule : flp_burst_gen

// file: hdl/link_mode_ctrl.sv
// speed, duplex and master/slave configuration and resolution
// Behaviour
// - enable strap low at reset selects forced mode, no negotiation
// - control bit 12 written zero disables negotiation over the strap
// - forced gigabit is test only; links only with same-family partners
// - forced mode takes speed from rate straps, duplex from duplex strap
// - duplex strap one is full duplex, zero half duplex
// - straps latched at reset; control bits 13,12,8,6 override them
// - forced codes 00/01/10 give 10/100/1000; 11 reserved
// - gigabit master uses local clock; slave uses recovered clock
// - negotiation strapped off: node strap low slave, high master
// - register 9 bits 12:11 override strapped master/slave role
// - same forced role both ends in forced gigabit mode sets fault bit 15, no link
// - forced role kept against negotiating partner; complements link
// - abilities exchanged in fast link pulse bursts
// - rate and duplex straps choose advertised abilities when negotiating
// - highest common mode wins, 1000fd down to 10hd
// - parallel detection gives 10 or 100 with non-negotiating partner
// - software may restart negotiation
`timescale 1ns/1ns
`include "link_mode_consts.svh"
module link_mode_ctrl (
    input wire logic ref_clk_i, // 10 mhz clock
    input wire logic rst_i, // sync reset, high
    input wire logic autoneg_enable_strap_i, // negotiation enable strap
    input wire logic [1:0] speed_strap_i, // rate select strap
    input wire logic duplex_strap_i, // duplex strap
    input wire logic node_strap_i, // node priority strap
    input wire logic ctrl_wr_i, // write strobe, control register
    input wire logic [15:0] ctrl_wdata_i, // control register write data
    input wire logic ms_wr_i, // write strobe, master/slave register
    input wire logic [15:0] ms_wdata_i, // master/slave register write data
    input wire logic gstat_rd_i, // read strobe, gigabit status
    input wire logic [5:0] lp_ability_i, // partner abilities, same layout
    input wire logic lp_ability_vld_i, // partner page received
    input wire logic lp_forced_i, // partner is forced master/slave
    input wire logic lp_master_i, // partner forced role is master
    input wire logic pd_link_i, // parallel detect saw link signal
    input wire logic pd_is_100_i, // parallel detect signal is 100 mb/s
    input wire logic lp_same_family_i, // partner supports forced gigabit
    output logic [15:0] basic_control_reg_o, // control register read value
    output logic [15:0] ms_ctrl_reg_o, // master/slave register read value
    output logic [15:0] gig_status_reg_o, // gigabit status read value
    output logic [1:0] speed_o, // resolved speed code
    output logic full_duplex_o, // resolved duplex
    output logic master_o, // resolved gigabit role
    output logic tx_clk_local_o, // transmit from local clock
    output logic link_up_o, // link established
    output logic an_active_o, // negotiation running
    output logic flp_pulse_o // link pulse to line driver
);
    typedef struct packed {
        link_mode_pkg::an_state_t st;
        logic strap_done;
        logic [15:0] ctrl;
        logic [15:0] ms;
        logic ms_fault;
        logic [1:0] spd;
        logic fdx;
        logic master;
        logic link;
        logic burst_req;
    } ctrl_state_t;

    ctrl_state_t s_r;
    ctrl_state_t s_nxt;
    mode_sel_if msel ();
    link_mode_pkg::ability_t adv;
    link_mode_pkg::ability_t common;

    // rate code to speed bits for forced mode
    function automatic logic [1:0] forced_speed(input logic [1:0] code);
        case (code)
            2'h0: forced_speed = `SPD_10;
            2'h1: forced_speed = `SPD_100;
            2'h2: forced_speed = `SPD_1000;
            default: forced_speed = `SPD_RSVD;
        endcase
    endfunction : forced_speed

    // speed field from control bits 6 (msb) and 13 (lsb)
    function automatic logic [1:0] ctrl_speed(input logic [15:0] c);
        ctrl_speed = {c[`CTRL_BIT_SPEED_MSB], c[`CTRL_BIT_SPEED_LSB]};
    endfunction : ctrl_speed

    // advertised ability word from speed code and duplex
    function automatic link_mode_pkg::ability_t adv_word(input logic [1:0] code,
                                                         input logic fd);
        logic g;
        logic h;
        logic t;
        g = 1'b1;
        h = (code == 2'h0) || (code == 2'h1);
        t = (code == 2'h0) || (code == 2'h3);
        adv_word = {g & fd, g, h & fd, h, t & fd, t};
    endfunction : adv_word

    // control bits map back to the rate code the straps use
    always_comb begin
        adv = adv_word(ctrl_speed(s_r.ctrl), s_r.ctrl[`CTRL_BIT_DUPLEX]);
        common = adv & lp_ability_i;
    end

    always_comb begin
        s_nxt = s_r;
        s_nxt.burst_req = 1'b0;
        // straps caught in the first clock after reset release
        if (!s_r.strap_done) begin
            s_nxt.strap_done = 1'b1;
            s_nxt.ctrl[`CTRL_BIT_AUTONEG_ENABLE_STRAP] = autoneg_enable_strap_i;
            s_nxt.ctrl[`CTRL_BIT_DUPLEX] = duplex_strap_i;
            s_nxt.ctrl[`CTRL_BIT_SPEED_MSB] = speed_strap_i[1];
            s_nxt.ctrl[`CTRL_BIT_SPEED_LSB] = speed_strap_i[0];
            // without negotiation the node strap forces the role
            s_nxt.ms[`MS_BIT_MANUAL] = !autoneg_enable_strap_i;
            s_nxt.ms[`MS_BIT_MASTER] = node_strap_i;
        end
        if (ctrl_wr_i) begin
            s_nxt.ctrl = ctrl_wdata_i;
            s_nxt.ctrl[`CTRL_BIT_RESTART] = 1'b0;
            s_nxt.link = 1'b0;
            s_nxt.st = link_mode_pkg::ST_IDLE;
        end
        if (ms_wr_i) begin
            s_nxt.ms = ms_wdata_i;
            s_nxt.link = 1'b0;
            s_nxt.st = link_mode_pkg::ST_IDLE;
        end
        // fault is sticky until read; a new fault in the read cycle wins
        if (gstat_rd_i)
            s_nxt.ms_fault = 1'b0;
        if (!ctrl_wr_i && !ms_wr_i && s_r.strap_done) begin
            case (s_r.st)
                link_mode_pkg::ST_IDLE: begin
                    s_nxt.link = 1'b0;
                    if (s_r.ctrl[`CTRL_BIT_AUTONEG_ENABLE_STRAP]) begin
                        s_nxt.st = link_mode_pkg::ST_NEGOTIATE;
                    end else begin
                        s_nxt.st = link_mode_pkg::ST_FORCED;
                    end
                end
                link_mode_pkg::ST_FORCED: begin
                    s_nxt.spd = forced_speed(ctrl_speed(s_r.ctrl));
                    s_nxt.fdx = s_r.ctrl[`CTRL_BIT_DUPLEX];
                    s_nxt.master = s_r.ms[`MS_BIT_MASTER];
                    if (forced_speed(ctrl_speed(s_r.ctrl)) == `SPD_RSVD) begin
                        s_nxt.link = 1'b0;
                    end else if (forced_speed(ctrl_speed(s_r.ctrl)) == `SPD_1000) begin
                        if (lp_forced_i && (lp_master_i == s_r.ms[`MS_BIT_MASTER])) begin
                            s_nxt.ms_fault = 1'b1;
                            s_nxt.link = 1'b0;
                            s_nxt.st = link_mode_pkg::ST_FAULT;
                        end else begin
                            // forced gigabit only pairs with same-family partners
                            s_nxt.link = lp_same_family_i;
                        end
                    end else begin
                        s_nxt.link = pd_link_i;
                    end
                end
                link_mode_pkg::ST_NEGOTIATE: begin
                    if (!msel.burst_busy && !s_r.burst_req)
                        s_nxt.burst_req = 1'b1;
                    if (lp_ability_vld_i && (common != 6'h00)) begin
                        s_nxt.st = link_mode_pkg::ST_LINKED;
                        s_nxt.link = 1'b1;
                        if (common[5] | common[4]) begin
                            s_nxt.spd = `SPD_1000;
                            s_nxt.fdx = common[5];
                        end else if (common[3] | common[2]) begin
                            s_nxt.spd = `SPD_100;
                            s_nxt.fdx = common[3];
                        end else begin
                            s_nxt.spd = `SPD_10;
                            s_nxt.fdx = common[1];
                        end
                        // a manual role is held against a negotiating partner
                        if (s_r.ms[`MS_BIT_MANUAL]) begin
                            s_nxt.master = s_r.ms[`MS_BIT_MASTER];
                        end else if (lp_forced_i) begin
                            s_nxt.master = !lp_master_i;
                        end else begin
                            s_nxt.master = node_strap_i;
                        end
                    end else if (!lp_ability_vld_i && pd_link_i) begin
                        // partner without negotiation: half duplex at detected rate
                        s_nxt.st = link_mode_pkg::ST_LINKED;
                        s_nxt.link = 1'b1;
                        s_nxt.spd = pd_is_100_i ? `SPD_100 : `SPD_10;
                        s_nxt.fdx = 1'b0;
                    end
                end
                link_mode_pkg::ST_LINKED: begin
                    if (!pd_link_i && !lp_ability_vld_i) begin
                        s_nxt.link = 1'b0;
                        s_nxt.st = link_mode_pkg::ST_IDLE;
                    end
                end
                link_mode_pkg::ST_FAULT: begin
                    s_nxt.link = 1'b0;
                    if (!(lp_forced_i && (lp_master_i == s_r.ms[`MS_BIT_MASTER])))
                        s_nxt.st = link_mode_pkg::ST_IDLE;
                end
                default: begin
                    s_nxt.st = link_mode_pkg::ST_IDLE;
                end
            endcase
        end
        // restart is self clearing and reopens negotiation
        if (ctrl_wr_i && ctrl_wdata_i[`CTRL_BIT_RESTART] && ctrl_wdata_i[`CTRL_BIT_AUTONEG_ENABLE_STRAP])
            s_nxt.st = link_mode_pkg::ST_NEGOTIATE;
    end

    always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
            s_r.st <= link_mode_pkg::ST_IDLE;
            s_r.strap_done <= 1'b0;
            s_r.ctrl <= `CTRL_RST_VAL;
            s_r.ms <= `MS_RST_VAL;
            s_r.ms_fault <= 1'b0;
            s_r.spd <= `SPD_10;
            s_r.fdx <= 1'b0;
            s_r.master <= 1'b0;
            s_r.link <= 1'b0;
            s_r.burst_req <= 1'b0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign msel.burst_req = s_r.burst_req;
    assign msel.adv_word = adv;

    flp_burst_gen u_flp (
        .ref_clk_i(ref_clk_i),
        .rst_i(rst_i),
        .ms(msel.gen),
        .flp_pulse_o(flp_pulse_o)
    );

    assign basic_control_reg_o = s_r.ctrl;
    assign ms_ctrl_reg_o = s_r.ms;
    assign gig_status_reg_o = {s_r.ms_fault, 15'h0000};
    assign speed_o = s_r.spd;
    assign full_duplex_o = s_r.fdx;
    assign master_o = s_r.master;
    // gigabit master drives from local clock, slave from recovered clock; 10/100 always local
    assign tx_clk_local_o = (s_r.spd == `SPD_1000) ? s_r.master : 1'b1;
    assign link_up_o = s_r.link;
    assign an_active_o = (s_r.st == link_mode_pkg::ST_NEGOTIATE);
endmodule : link_mode_ctrl

// file: verif/link_mode_properties.sv
// port assertions for the link mode resolver
`timescale 1ns/1ns
`include "link_mode_consts.svh"
module link_mode_properties (
    input wire logic ref_clk_i, // clock
    input wire logic rst_i, // reset
    input wire logic [5:0] lp_ability_i, // partner page
    input wire logic lp_ability_vld_i, // page valid
    input wire logic lp_forced_i, // partner forced
    input wire logic lp_master_i, // partner master
    input wire logic pd_link_i, // detect seen
    input wire logic pd_is_100_i, // detect speed
    input wire logic [15:0] basic_control_reg_o, // control
    input wire logic [15:0] ms_ctrl_reg_o, // role reg
    input wire logic [15:0] gig_status_reg_o, // status
    input wire logic [1:0] speed_o, // speed
    input wire logic full_duplex_o, // duplex
    input wire logic master_o, // role
    input wire logic tx_clk_local_o, // clock source
    input wire logic link_up_o, // link
    input wire logic an_active_o, // negotiating
    input wire logic flp_pulse_o // pulse
);
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    logic [2:0] quiet_r; // cycles with nothing changed, saturates
    logic [15:0] c;
    logic [2:0] sp;
    logic [5:0] com;
    logic [2:0] best; // {speed, duplex} of highest common bit
    logic [42:0] watch; // everything the checks below depend on
    assign c = basic_control_reg_o;
    assign watch = {c, ms_ctrl_reg_o, lp_ability_i, lp_ability_vld_i, lp_forced_i, lp_master_i,
        pd_link_i, pd_is_100_i};
    always_comb begin
        case ({c[6], c[13]})
            2'h0: sp = 3'h7;
            2'h1: sp = 3'h6;
            2'h2: sp = 3'h4;
            default: sp = 3'h5;
        endcase
        com = {sp[2] & c[8], sp[2], sp[1] & c[8], sp[1], sp[0] & c[8], sp[0]} & lp_ability_i;
        best = 3'h0;
        for (int i = 0; i < 6; i++) begin
            if (com[i]) best = i[2:0];
        end
    end
    always_ff @(posedge ref_clk_i) begin
        if (rst_i || !$stable(watch)) quiet_r <= 3'h0;
        else if (quiet_r != 3'h7) quiet_r <= quiet_r + 3'h1;
    end
    chk_tx_clk_src: assert property (tx_clk_local_o == !(speed_o == `SPD_1000 && !master_o))
        else $error("transmit clock source wrong");
    chk_forced_mode: assert property (link_up_o && !c[12] && quiet_r > 3'h3
        && $stable(watch) |-> speed_o == {c[6], c[13]} && full_duplex_o == c[8])
        else $error("forced mode wrong");
    chk_rsvd_code: assert property (!c[12] && {c[6], c[13]} == `SPD_RSVD && quiet_r > 3'h3
        && $stable(watch) |-> !link_up_o) else $error("reserved speed linked");
    chk_forced_quiet: assert property (!c[12] && quiet_r > 3'h3
        && $stable(watch) |-> !an_active_o && !flp_pulse_o)
        else $error("negotiation active when off");
    chk_role_kept: assert property (link_up_o && speed_o == `SPD_1000 && ms_ctrl_reg_o[12]
        && quiet_r > 3'h3 && $stable(watch) |-> master_o == ms_ctrl_reg_o[11])
        else $error("forced role lost");
    chk_same_role: assert property (!c[12] && {c[6], c[13]} == `SPD_1000 && ms_ctrl_reg_o[12]
        && lp_forced_i && lp_master_i == ms_ctrl_reg_o[11] && quiet_r > 3'h3 && $stable(watch)
        |-> !link_up_o && gig_status_reg_o[15]) else $error("role clash not reported");
    chk_best_mode: assert property (link_up_o && c[12] && lp_ability_vld_i && com != 6'h00
        && quiet_r > 3'h0 && $stable(watch) |-> {speed_o, full_duplex_o} == best)
        else $error("not best mode");
    chk_pd_half: assert property (link_up_o && c[12] && !lp_ability_vld_i && quiet_r > 3'h3
        && $stable(watch) |-> !full_duplex_o && speed_o == {1'b0, pd_is_100_i})
        else $error("detect mode wrong");
    chk_flp_single: assert property (flp_pulse_o |=> !flp_pulse_o)
        else $error("pulse longer than a cycle");
    cov_gig: cover property (link_up_o && speed_o == `SPD_1000);
    cov_fault: cover property (gig_status_reg_o[15]);
    cov_neg: cover property (link_up_o && c[12] && lp_ability_vld_i);
endmodule : link_mode_properties
bind link_mode_ctrl link_mode_properties u_chk (.ref_clk_i, .rst_i, .lp_ability_i,
    .lp_ability_vld_i, .lp_forced_i, .lp_master_i, .pd_link_i, .pd_is_100_i,
    .basic_control_reg_o, .ms_ctrl_reg_o, .gig_status_reg_o, .speed_o, .full_duplex_o,
    .master_o, .tx_clk_local_o, .link_up_o, .an_active_o, .flp_pulse_o);

// file: verif/lp_model.sv
// remote partner: answers pulse bursts with its ability page
`timescale 1ns/1ns
module lp_model (
    input wire logic ref_clk_i, // clock
    input wire logic rst_i, // reset
    input wire logic neg_i, // partner negotiates
    input wire logic [5:0] abil_i, // partner abilities
    input wire logic flp_pulse_i, // pulses from the device
    output logic [5:0] lp_ability_o, // page bits
    output logic lp_ability_vld_o, // page received
    output logic [7:0] pulses_o // pulses seen
);
    always_ff @(posedge ref_clk_i) begin
        if (rst_i || !neg_i) lp_ability_vld_o <= 1'b0;
        else if (flp_pulse_i) lp_ability_vld_o <= 1'b1;
        if (rst_i) pulses_o <= 8'h00;
        else if (flp_pulse_i) pulses_o <= pulses_o + 8'h01;
    end
    // no page held: show the inverse, never a stale valid-looking value
    assign lp_ability_o = lp_ability_vld_o ? abil_i : ~abil_i;
endmodule : lp_model

// file: verif/tb_link_mode_ctrl.sv
// bench for the link mode resolver
`timescale 1ns/1ns
module tb_link_mode_ctrl;
    logic ref_clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic an_s = 1'b0;
    logic [1:0] spd_s = 2'h1;
    logic dup_s = 1'b1;
    logic ctrl_wr = 1'b0;
    logic ms_wr = 1'b0;
    logic [15:0] wd = 16'h0000;
    logic gstat_rd = 1'b0;
    logic lp_neg = 1'b0;
    logic [5:0] lp_abil = 6'h00;
    logic lp_forced = 1'b0;
    logic lp_master = 1'b0;
    logic pd_link = 1'b1; // forced 10/100 links only with partner signal present
    logic node_s = 1'b1;
    logic pd_100 = 1'b0;
    logic same_fam = 1'b1;
    logic [5:0] lp_ab;
    logic lp_vld, fd_q, mst_q, txl_q, link_q, an_q, flp;
    logic [7:0] pulses;
    logic [15:0] ctrl_q, ms_q, gst_q;
    logic [1:0] spd_q;
    logic [2:0] k;
    // {rate code, duplex, partner abilities, expected speed, expected duplex}
    logic [11:0] neg_tab [5] = '{12'h3fd, 12'h1fc, 12'h67b, 12'he79, 12'h032};
    int errors = 0;
    int n_compared = 0;
    int cyc = 0;
    always #50 ref_clk_i = ~ref_clk_i;
    link_mode_ctrl u_dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .autoneg_enable_strap_i(an_s),
        .speed_strap_i(spd_s), .duplex_strap_i(dup_s), .node_strap_i(node_s), .ctrl_wr_i(ctrl_wr),
        .ctrl_wdata_i(wd), .ms_wr_i(ms_wr), .ms_wdata_i(wd), .gstat_rd_i(gstat_rd),
        .lp_ability_i(lp_ab), .lp_ability_vld_i(lp_vld), .lp_forced_i(lp_forced),
        .lp_master_i(lp_master), .pd_link_i(pd_link), .pd_is_100_i(pd_100),
        .lp_same_family_i(same_fam), .basic_control_reg_o(ctrl_q), .ms_ctrl_reg_o(ms_q),
        .gig_status_reg_o(gst_q), .speed_o(spd_q), .full_duplex_o(fd_q), .master_o(mst_q),
        .tx_clk_local_o(txl_q), .link_up_o(link_q), .an_active_o(an_q), .flp_pulse_o(flp));
    lp_model u_lp (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .neg_i(lp_neg), .abil_i(lp_abil),
        .flp_pulse_i(flp), .lp_ability_o(lp_ab), .lp_ability_vld_o(lp_vld), .pulses_o(pulses));
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic wr(input logic to_ms, input logic [15:0] d);
        @(posedge ref_clk_i);
        ctrl_wr <= !to_ms;
        ms_wr <= to_ms;
        wd <= d;
        @(posedge ref_clk_i);
        ctrl_wr <= 1'b0;
        ms_wr <= 1'b0;
    endtask : wr
    // a write sends the resolver back to idle, so let the old link drop first
    task automatic wait_link(input int n);
        repeat (6) @(negedge ref_clk_i);
        for (int j = 0; j < n && link_q !== 1'b1; j++) @(negedge ref_clk_i);
    endtask : wait_link
    task automatic test_done;
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : test_done
    always @(posedge ref_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            errors++;
            test_done;
        end
    end
    initial begin
        repeat (5) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        repeat (3) @(negedge ref_clk_i);
        check("strap ctrl", ctrl_q, 16'h2100);
        check("strap role", ms_q, 16'h1800);
        @(posedge ref_clk_i);
        an_s <= 1'b1;
        spd_s <= 2'h2;
        wait_link(20);
        check("strap link", 16'(link_q), 16'h0001);
        check("strap speed", 16'(spd_q), 16'h0001);
        check("strap duplex", 16'(fd_q), 16'h0001);
        check("strap an", 16'(an_q), 16'h0000);
        $display("test strap done");
        for (int i = 0; i < 8; i++) begin
            k = i[2:0];
            wr(1'b0, {2'b00, k[0], 1'b0, 3'h0, k[2], 1'b0, k[1], 6'h00});
            wait_link(10);
            check("forced ctrl", ctrl_q, {2'b00, k[0], 1'b0, 3'h0, k[2], 1'b0, k[1], 6'h00});
            check("forced link", 16'(link_q), 16'(k[1:0] != 2'h3));
            if (k[1:0] != 2'h3) check("forced speed", 16'(spd_q), 16'(k[1:0]));
            if (k[1:0] != 2'h3) check("forced duplex", 16'(fd_q), 16'(k[2]));
        end
        @(posedge ref_clk_i) same_fam <= 1'b0;
        wr(1'b0, 16'h0140);
        wait_link(10);
        check("family link", 16'(link_q), 16'h0000);
        @(posedge ref_clk_i) same_fam <= 1'b1;
        for (int i = 0; i < 2; i++) begin
            wr(1'b1, i ? 16'h1000 : 16'h1800);
            wr(1'b0, 16'h0140);
            wait_link(10);
            check("forced role", 16'(mst_q), 16'(i == 0));
            check("tx clock", 16'(txl_q), 16'(i == 0));
        end
        @(posedge ref_clk_i) lp_forced <= 1'b1;
        wr(1'b0, 16'h0140);
        wait_link(10);
        check("clash fault", 16'(gst_q[15]), 16'h0001);
        check("clash link", 16'(link_q), 16'h0000);
        @(posedge ref_clk_i) lp_master <= 1'b1;
        wr(1'b0, 16'h0140);
        wait_link(10);
        check("fault sticky", 16'(gst_q[15]), 16'h0001);
        check("pair link", 16'(link_q), 16'h0001);
        @(posedge ref_clk_i) gstat_rd <= 1'b1;
        @(posedge ref_clk_i) gstat_rd <= 1'b0;
        @(negedge ref_clk_i);
        check("fault clear", 16'(gst_q[15]), 16'h0000);
        @(posedge ref_clk_i);
        lp_forced <= 1'b0;
        pd_link <= 1'b0;
        $display("test forced done");
        foreach (neg_tab[i]) begin
            // old page must drop before the new abilities appear
            @(posedge ref_clk_i) lp_neg <= 1'b0;
            @(posedge ref_clk_i) lp_abil <= neg_tab[i][8:3];
            wr(1'b0, {2'b00, neg_tab[i][10], 3'b100, 1'b1, neg_tab[i][9], 1'b0,
                neg_tab[i][11], 6'h00});
            lp_neg <= 1'b1;
            wait_link(6000);
            check("neg link", 16'(link_q), 16'h0001);
            check("neg speed", 16'(spd_q), 16'(neg_tab[i][2:1]));
            check("neg duplex", 16'(fd_q), 16'(neg_tab[i][0]));
        end
        check("pulses seen", 16'(pulses != 8'h00), 16'h0001);
        @(posedge ref_clk_i);
        lp_neg <= 1'b0;
        pd_link <= 1'b1;
        for (int i = 0; i < 2; i++) begin
            @(posedge ref_clk_i) pd_100 <= i[0];
            wr(1'b0, 16'h1200);
            wait_link(6000);
            check("detect link", 16'(link_q), 16'h0001);
            check("detect speed", 16'(spd_q), 16'(i));
            check("detect duplex", 16'(fd_q), 16'h0000);
        end
        $display("test negotiate done");
        // second reset with the node strap low: strapped slave role
        @(posedge ref_clk_i);
        rst_i <= 1'b1;
        an_s <= 1'b0;
        node_s <= 1'b0;
        repeat (5) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        repeat (3) @(negedge ref_clk_i);
        check("reset ctrl", ctrl_q, 16'h0140);
        check("reset role", ms_q, 16'h1000);
        wait_link(20);
        check("reset link", 16'(link_q), 16'h0001);
        check("reset master", 16'(mst_q), 16'h0000);
        check("reset tx clock", 16'(txl_q), 16'h0000);
        $display("test reset done");
        test_done;
    end
endmodule : tb_link_mode_ctrl
